/* File: fcd_pkg.sv */
// Package: command codes, modes and timing constants of the flash command decoder
package fcd_pkg;

  // ----------------------------------------
  // Command codes
  // ----------------------------------------
  localparam logic [7:0] FCD_CMD_READ_ARRAY   = 8'hFF;
  localparam logic [7:0] FCD_CMD_READ_ID      = 8'h90;
  localparam logic [7:0] FCD_CMD_READ_QUERY   = 8'h98;
  localparam logic [7:0] FCD_CMD_READ_STATUS  = 8'h70;
  localparam logic [7:0] FCD_CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] FCD_CMD_WORD_PGM     = 8'h40;
  localparam logic [7:0] FCD_CMD_WORD_PGM_ALT = 8'h10;
  localparam logic [7:0] FCD_CMD_BUF_PGM      = 8'hE8;
  localparam logic [7:0] FCD_CMD_CONFIRM      = 8'hD0;
  localparam logic [7:0] FCD_CMD_EFP_SETUP    = 8'h80;
  localparam logic [7:0] FCD_CMD_ERASE_SETUP  = 8'h20;
  localparam logic [7:0] FCD_CMD_SUSPEND      = 8'hB0;
  localparam logic [7:0] FCD_CMD_LOCK_SETUP   = 8'h60;
  localparam logic [7:0] FCD_CMD_LOCK_BLOCK   = 8'h01;
  localparam logic [7:0] FCD_CMD_LOCK_DOWN    = 8'h2F;
  localparam logic [7:0] FCD_CMD_CFG_CONFIRM  = 8'h03;
  localparam logic [7:0] FCD_CMD_PROT_PGM     = 8'hC0;

  // ----------------------------------------
  // Sizes, reset values, status bits
  // ----------------------------------------
  localparam int          FCD_BUF_WORDS     = 32;
  localparam logic [7:0]  FCD_STATUS_RESET  = 8'h80;
  localparam int          FCD_STAT_READY_BIT = 7;
  localparam int          FCD_STAT_SUSP_BIT  = 6;
  localparam int          FCD_STAT_ERASE_BIT = 5;
  localparam int          FCD_STAT_PGM_BIT   = 4;
  localparam int          FCD_CLK_MHZ       = 20;
  localparam int          FCD_OP_TIME_US    = 20;
  localparam int          FCD_OP_CYCLES     = FCD_OP_TIME_US * FCD_CLK_MHZ;
  localparam int          FCD_HOST_WE_CYC   = 2;

  // ----------------------------------------
  // Read modes and operation kinds
  // ----------------------------------------
  typedef enum logic [3:0] {
    FCD_RD_ARRAY  = 4'h1,
    FCD_RD_ID     = 4'h2,
    FCD_RD_QUERY  = 4'h4,
    FCD_RD_STATUS = 4'h8
  } fcd_read_mode_e;

  typedef enum logic [3:0] {
    FCD_OP_NONE    = 4'h0,
    FCD_OP_PROGRAM = 4'h1,
    FCD_OP_ERASE   = 4'h2,
    FCD_OP_LOCK    = 4'h3,
    FCD_OP_PROT    = 4'h4,
    FCD_OP_CONFIG  = 4'h5,
    FCD_OP_BUF     = 4'h6,
    FCD_OP_EFP     = 4'h7,
    FCD_OP_UNLOCK  = 4'h8,
    FCD_OP_LDOWN   = 4'h9
  } fcd_op_e;

endpackage : fcd_pkg

/* File: fcd_bus_if.sv */
// Interface: write side of the parallel flash bus between host and decoder
`timescale 1ns/1ns
interface fcd_bus_if;
  logic        we_n;      // Write strobe, address and data taken on its rising edge
  logic [23:0] addr;      // Word address
  logic [15:0] wdata;     // Host write data
  logic        rst_n;     // Hardware reset pin from host, active low

  modport device_mp (
    input we_n,
    input addr,
    input wdata,
    input rst_n
  );

  modport host_mp (
    output we_n,
    output addr,
    output wdata,
    output rst_n
  );
endinterface : fcd_bus_if

/* File: fcd_host.sv */
// Host end: turns one-word command requests into timed write cycles on the bus
`timescale 1ns/1ns
module fcd_host
  import fcd_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        arst_n_i,
  input  wire logic        req_i,        // One write request, taken when idle
  input  wire logic [23:0] req_addr_i,
  input  wire logic [15:0] req_data_i,
  input  wire logic        hw_reset_i,   // Level: hold flash reset pin low
  output logic             busy_o,
  output logic             done_o,
  fcd_bus_if.host_mp       bus
);

  // ----------------------------------------
  // Write cycle generator
  // ----------------------------------------
  // The caller orders the command words; a multi-cycle command should target
  // the same address on its first cycle as on its target cycle.
  // Identifier and query reads are addressed die base plus offset.
  logic [1:0]  cnt;
  logic        we_n;
  logic [23:0] addr;
  logic [15:0] wdata;
  logic        rst_n;

  wire start = req_i && !busy_o;
  wire last  = busy_o && (cnt == 2'(FCD_HOST_WE_CYC - 1));

  // Strobe low for two cycles; rising edge latches the word
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      busy_o <= 1'b0;
      done_o <= 1'b0;
      cnt    <= 2'h0;
      we_n   <= 1'b1;
      addr   <= 24'h000000;
      wdata  <= 16'h0000;
      rst_n  <= 1'b0;
    end
    else
    begin
      rst_n  <= !hw_reset_i;
      done_o <= last;
      if (start)
      begin
        busy_o <= 1'b1;
        we_n   <= 1'b0;
        addr   <= req_addr_i;
        wdata  <= req_data_i;
        cnt    <= 2'h0;
      end
      else if (last)
      begin
        busy_o <= 1'b0;
        we_n   <= 1'b1;
      end
      else if (busy_o)
        cnt <= cnt + 2'h1;
    end
  end

  assign bus.we_n  = we_n;
  assign bus.addr  = addr;
  assign bus.wdata = wdata;
  assign bus.rst_n = rst_n;

endmodule : fcd_host

/* File: fcd_device.sv */
// Device end: command decoder and write state machine sequencing
`timescale 1ns/1ns
module fcd_device
  import fcd_pkg::*;
#(
  parameter int BUF_WORDS = FCD_BUF_WORDS,
  parameter int OP_CYCLES = FCD_OP_CYCLES
)
(
  input  wire logic        mclk_i,
  input  wire logic        arst_n_i,
  input  wire logic        efp_exit_i,   // Pulse: array side ends factory mode
  output logic [3:0]       read_mode_o,
  output logic [7:0]       status_o,
  output logic [3:0]       op_kind_o,
  output logic             op_start_o,   // Pulse with op_addr valid (op_data too for word and register program), except a config op, which loads config_o
  output logic [23:0]      op_addr_o,
  output logic [15:0]      op_data_o,
  output logic             buf_wr_o,     // Pulse per buffered word
  output logic [4:0]       buf_idx_o,
  output logic [15:0]      config_o,
  output logic             busy_o,
  output logic             suspended_o,
  output logic             aborted_o,
  fcd_bus_if.device_mp     bus
);
  // ----------------------------------------
  // Write strobe edge detect
  // ----------------------------------------
  logic we_d;
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      we_d <= 1'b1;
    else
      we_d <= bus.we_n;
  end
  wire       wr  = bus.we_n && !we_d && bus.rst_n;
  wire [7:0] cmd = bus.wdata[7:0];

  // ----------------------------------------
  // Decoder state
  // ----------------------------------------
  typedef enum logic [8:0] {
    S_IDLE    = 9'h001,
    S_WORD    = 9'h002,
    S_BCOUNT  = 9'h004,
    S_BDATA   = 9'h008,
    S_BCONF   = 9'h010,
    S_EFPCONF = 9'h020,
    S_EFPDATA = 9'h040,
    S_ERASE   = 9'h080,
    S_SECOND  = 9'h100
  } fcd_state_e;
  fcd_state_e state;
  logic [7:0] setup;          // Remembers first code for shared second cycle
  logic [4:0] left;           // Buffer words still to load, minus one
  logic [$clog2(OP_CYCLES+1)-1:0] timer;
  logic       running;
  // Array operation start decode
  wire go_word  = (state == S_WORD);
  wire go_buf   = (state == S_BCONF) && (cmd == FCD_CMD_CONFIRM);
  wire go_erase = (state == S_ERASE) && (cmd == FCD_CMD_CONFIRM);
  wire bad_ers  = (state == S_ERASE) && (cmd != FCD_CMD_CONFIRM);
  wire go_efp   = (state == S_EFPCONF) && (cmd == FCD_CMD_CONFIRM);
  wire resume   = (state == S_IDLE) && suspended_o && (cmd == FCD_CMD_CONFIRM);
  wire efp_end  = efp_exit_i && (state == S_EFPDATA);  // Factory mode has no timer, so this frees busy
  wire finish   = (running && !suspended_o && (timer == 1)) || efp_end;
  // ----------------------------------------
  // Command sequencing
  // ----------------------------------------
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state       <= S_IDLE;
      setup       <= 8'h00;
      left        <= 5'h00;
      read_mode_o <= FCD_RD_ARRAY;
      status_o    <= FCD_STATUS_RESET;
      op_kind_o   <= FCD_OP_NONE;
      op_start_o  <= 1'b0;
      op_addr_o   <= 24'h000000;
      op_data_o   <= 16'h0000;
      buf_wr_o    <= 1'b0;
      buf_idx_o   <= 5'h00;
      config_o    <= 16'h0000;
      busy_o      <= 1'b0;
      running     <= 1'b0;
      timer       <= '0;
      suspended_o <= 1'b0;
      aborted_o   <= 1'b0;
    end
    else if (!bus.rst_n)
    begin
      // Pin reset: abort, back to array read
      aborted_o   <= aborted_o || running;
      running     <= 1'b0;
      busy_o      <= 1'b0;
      suspended_o <= 1'b0;
      state       <= S_IDLE;
      read_mode_o <= FCD_RD_ARRAY;
      status_o    <= FCD_STATUS_RESET;
      op_start_o  <= 1'b0;
      buf_wr_o    <= 1'b0;
    end
    else
    begin
      op_start_o <= 1'b0;
      buf_wr_o   <= 1'b0;
      // Internal timer needs no host cycles
      if (running && !suspended_o && timer != 0)
        timer <= timer - 1'b1;
      if (finish)
      begin
        running <= 1'b0;
        busy_o  <= 1'b0;
        status_o[FCD_STAT_READY_BIT] <= 1'b1;
      end
      if (efp_end)
        state <= S_IDLE;
      if (wr)
      begin
        unique case (state)
          S_IDLE:
          begin
            if (running && !suspended_o)
            begin
              // Busy: only status read and suspend heard
              if (cmd == FCD_CMD_READ_STATUS)
                read_mode_o <= FCD_RD_STATUS;
              else if (cmd == FCD_CMD_SUSPEND)
              begin
                suspended_o <= 1'b1;
                status_o[FCD_STAT_READY_BIT:FCD_STAT_SUSP_BIT] <= 2'b11;
                read_mode_o <= FCD_RD_STATUS;
              end
            end
            else if (resume)
            begin
              suspended_o <= 1'b0;
              status_o[FCD_STAT_READY_BIT:FCD_STAT_SUSP_BIT] <= 2'b00;
              read_mode_o <= FCD_RD_STATUS;
            end
            else
            begin
              setup <= cmd;
              unique case (cmd)
                FCD_CMD_READ_ARRAY:   read_mode_o <= FCD_RD_ARRAY;
                FCD_CMD_READ_ID:      read_mode_o <= FCD_RD_ID;
                FCD_CMD_READ_QUERY:   read_mode_o <= FCD_RD_QUERY;
                FCD_CMD_READ_STATUS:  read_mode_o <= FCD_RD_STATUS;
                FCD_CMD_CLEAR_STATUS: status_o[5:1] <= 5'h00;
                FCD_CMD_WORD_PGM,
                FCD_CMD_WORD_PGM_ALT: state <= S_WORD;
                FCD_CMD_BUF_PGM:      state <= S_BCOUNT;
                FCD_CMD_EFP_SETUP:    state <= S_EFPCONF;
                FCD_CMD_ERASE_SETUP:  state <= S_ERASE;
                FCD_CMD_LOCK_SETUP,
                FCD_CMD_PROT_PGM:     state <= S_SECOND;
                default:              state <= S_IDLE;
              endcase
            end
          end
          S_BCOUNT:
          begin
            left      <= bus.wdata[4:0];
            buf_idx_o <= 5'h1F;  // Wraps to zero on the first word
            state     <= S_BDATA;
          end
          S_BDATA:
          begin
            // Count is capped by the 5-bit field at the buffer size
            buf_wr_o  <= 1'b1;
            op_data_o <= bus.wdata;
            op_addr_o <= bus.addr;
            buf_idx_o <= buf_idx_o + 5'h01;
            if (left == 0)
              state <= S_BCONF;
            else
              left <= left - 5'h01;
          end
          S_EFPDATA:
          begin
            // Factory mode: stream data words, ignore everything else
            buf_wr_o  <= 1'b1;
            op_data_o <= bus.wdata;
          end
          S_SECOND:
          begin
            state <= S_IDLE;
            if (setup == FCD_CMD_PROT_PGM)
            begin
              // Protection or lock register word; address tells which
              op_kind_o  <= FCD_OP_PROT;
              op_start_o <= 1'b1;
              op_addr_o  <= bus.addr;
              op_data_o  <= bus.wdata;
              running    <= 1'b1;
              busy_o     <= 1'b1;
              timer      <= ($clog2(OP_CYCLES+1))'(OP_CYCLES);
              status_o[FCD_STAT_READY_BIT] <= 1'b0;
              read_mode_o <= FCD_RD_STATUS;
            end
            else if (cmd == FCD_CMD_CFG_CONFIRM)
            begin
              config_o   <= bus.addr[15:0];
              op_kind_o  <= FCD_OP_CONFIG;
              op_start_o <= 1'b1;
            end
            else if (cmd == FCD_CMD_LOCK_BLOCK || cmd == FCD_CMD_CONFIRM || cmd == FCD_CMD_LOCK_DOWN)
            begin
              op_kind_o  <= (cmd == FCD_CMD_LOCK_BLOCK) ? FCD_OP_LOCK :
                            (cmd == FCD_CMD_CONFIRM) ? FCD_OP_UNLOCK : FCD_OP_LDOWN;
              op_addr_o  <= bus.addr;
              op_start_o <= 1'b1;
            end
          end
          default:
          begin
            // Second cycle of word, erase or factory sequence, or confirm cycle of buffer sequence
            state <= S_IDLE;
            if (go_efp)
              state <= S_EFPDATA;
            if (bad_ers)
            begin
              status_o[FCD_STAT_ERASE_BIT:FCD_STAT_PGM_BIT] <= 2'b11;
              read_mode_o <= FCD_RD_STATUS;
            end
            if (go_word || go_buf || go_erase || go_efp)
            begin
              op_kind_o  <= go_word ? FCD_OP_PROGRAM : go_buf ? FCD_OP_BUF :
                            go_erase ? FCD_OP_ERASE : FCD_OP_EFP;
              op_start_o <= 1'b1;
              op_addr_o  <= bus.addr;
              op_data_o  <= go_word ? bus.wdata : op_data_o;
              running    <= !go_efp;
              busy_o     <= 1'b1;
              timer      <= ($clog2(OP_CYCLES+1))'(OP_CYCLES);
              status_o[FCD_STAT_READY_BIT] <= 1'b0;
              read_mode_o <= FCD_RD_STATUS;
            end
          end
        endcase
      end
    end
  end

endmodule : fcd_device

/* File: fcd_properties.sv */
// Checker: bus strobe and command decoding properties of the flash command decoder
`timescale 1ns/1ns
module fcd_properties
  import fcd_pkg::*;
#(
  parameter int OP_CYCLES = FCD_OP_CYCLES
)
(
  input wire logic        mclk_i,
  input wire logic        arst_n_i,
  input wire logic        we_n,
  input wire logic [23:0] addr,
  input wire logic [15:0] wdata,
  input wire logic        rst_n,
  input wire logic [3:0]  read_mode_o,
  input wire logic [7:0]  status_o,
  input wire logic        op_start_o,
  input wire logic        busy_o,
  input wire logic        suspended_o,
  input wire logic        aborted_o
);
  // ----------------------------------------
  // Helper logic
  // ----------------------------------------
  logic        we_q;
  logic [7:0]  code1;
  logic [7:0]  code2;
  logic [15:0] run_cnt;
  // Last two codes; only one-cycle codes (read modes and clear status) count as a clean command start
  wire         wr   = we_n && !we_q && rst_n;
  wire  [7:0]  cmd  = wdata[7:0];
  wire         idle = !busy_o && !suspended_o;
  wire         s1   = code1 inside {8'hFF, 8'h90, 8'h98, 8'h70, 8'h50};
  wire         s2   = code2 inside {8'hFF, 8'h90, 8'h98, 8'h70, 8'h50};

  // Strobe history and a run-length counter of unsuspended busy time
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      we_q    <= 1'b1;
      code1   <= 8'hFF;
      code2   <= 8'hFF;
      run_cnt <= '0;
    end
    else if (!rst_n)
    begin
      // Pin reset: history restarts, strobe tracking goes on like the decoder's
      we_q    <= we_n;
      code1   <= 8'hFF;
      code2   <= 8'hFF;
      run_cnt <= '0;
    end
    else
    begin
      we_q    <= we_n;
      code1   <= wr ? cmd : code1;
      code2   <= wr ? code1 : code2;
      run_cnt <= (busy_o && !suspended_o) ? run_cnt + 16'h0001 : '0;
    end
  end

  default clocking @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_array_select: assert property (wr && s1 && idle && cmd == 8'hFF |-> ##[1:3] read_mode_o == FCD_RD_ARRAY)
    else $error("array read mode not selected");
  a_ident_select: assert property (wr && s1 && idle && cmd == 8'h90 |-> ##[1:3] read_mode_o == FCD_RD_ID)
    else $error("identifier mode not selected");
  a_query_select: assert property (wr && s1 && idle && cmd == 8'h98 |-> ##[1:3] read_mode_o == FCD_RD_QUERY)
    else $error("query mode not selected");
  a_status_select: assert property (wr && s1 && idle && cmd == 8'h70 |-> ##[1:3] read_mode_o == FCD_RD_STATUS)
    else $error("status mode not selected");
  a_erase_start: assert property (wr && s2 && code1 == 8'h20 && idle && cmd == 8'hD0 |->
    ##[1:3] op_start_o ##[0:2] (busy_o && !status_o[7] && read_mode_o == FCD_RD_STATUS))
    else $error("erase did not start in status mode");
  a_bad_confirm: assert property (wr && s2 && code1 == 8'h20 && idle && cmd != 8'hD0 |->
    ##[1:3] (status_o[5:4] == 2'b11 && read_mode_o == FCD_RD_STATUS))
    else $error("bad erase confirm not flagged");
  a_clear_errors: assert property (wr && s1 && idle && cmd == 8'h50 |-> ##[1:3] status_o[5:4] == 2'b00)
    else $error("error bits not cleared");
  a_op_bounded: assert property (run_cnt <= OP_CYCLES + 2)
    else $error("internal operation overran its time");
  a_pin_abort: assert property (!rst_n && busy_o |->
    ##[1:2] (aborted_o && !busy_o && read_mode_o == FCD_RD_ARRAY && status_o == FCD_STATUS_RESET))
    else $error("pin reset did not abort operation");
  a_strobe_hold: assert property ($fell(we_n) |=> (!we_n && $stable(addr) && $stable(wdata)) ##1 we_n)
    else $error("write strobe shape or hold wrong");

  c_erase: cover property (wr && code1 == 8'h20 && cmd == 8'hD0);
  c_bad_confirm: cover property (wr && code1 == 8'h20 && cmd == 8'hFF);
  c_abort: cover property (!rst_n && busy_o);
endmodule : fcd_properties

/* File: testbench.sv */
// Testbench: command sequences from the host end through the bus to the decoder end
`timescale 1ns/1ns
module testbench
  import fcd_pkg::*;
;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  localparam int OPC = 40;   // Short op time, still long enough to write during it
  logic        mclk_i     = 1'b0;
  logic        arst_n_i   = 1'b0;
  logic        req_i      = 1'b0;
  logic [23:0] req_addr_i = '0;
  logic [15:0] req_data_i = '0;
  logic        hw_reset_i = 1'b0;
  logic        efp_exit_i = 1'b0;
  logic        h_busy, h_done, op_start, buf_wr, d_busy, susp, aborted;
  logic [3:0]  rd_mode, op_kind;
  logic [7:0]  status;
  logic [23:0] op_addr;
  logic [15:0] op_data, cfg;
  logic [4:0]  buf_idx;
  int          num_errors = 0;
  int          n_compared = 0;
  int          nbuf       = 0;

  fcd_bus_if bus_if ();
  fcd_host u_fcd_host (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .req_i(req_i), .req_addr_i(req_addr_i),
    .req_data_i(req_data_i), .hw_reset_i(hw_reset_i), .busy_o(h_busy), .done_o(h_done), .bus(bus_if));
  fcd_device #(.OP_CYCLES(OPC)) u_fcd_device (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .efp_exit_i(efp_exit_i),
    .read_mode_o(rd_mode), .status_o(status), .op_kind_o(op_kind), .op_start_o(op_start), .op_addr_o(op_addr),
    .op_data_o(op_data), .buf_wr_o(buf_wr), .buf_idx_o(buf_idx), .config_o(cfg), .busy_o(d_busy),
    .suspended_o(susp), .aborted_o(aborted), .bus(bus_if));
  fcd_properties #(.OP_CYCLES(OPC)) u_props (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .we_n(bus_if.we_n),
    .addr(bus_if.addr), .wdata(bus_if.wdata), .rst_n(bus_if.rst_n), .read_mode_o(rd_mode), .status_o(status),
    .op_start_o(op_start), .busy_o(d_busy), .suspended_o(susp), .aborted_o(aborted));

  // Clock and buffered-word counter
  always #25 mclk_i = ~mclk_i;
  always @(negedge mclk_i)
    if (buf_wr === 1'b1)
      nbuf++;

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run

  task automatic check(input logic [47:0] got, input logic [47:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask : check

  // Bounded waits; a wait that runs out ends the run as a mismatch
  task automatic give_up(input string what);
    num_errors++;
    $display("CHECK FAILED at %0t: timeout %s", $time, what);
    complete_run();
  endtask : give_up

  task automatic wr(input logic [23:0] a, input logic [15:0] d);
    int n;
    n = 0;
    req_addr_i = a;
    req_data_i = d;
    req_i      = 1'b1;
    @(negedge mclk_i);
    req_i = 1'b0;
    while (h_done !== 1'b1 && n < 20)
    begin
      @(negedge mclk_i);
      n++;
    end
    if (n == 20)
      give_up("host write");
    repeat (2) @(negedge mclk_i);   // Decoder registers the strobe, then answers
  endtask : wr

  task automatic wait_idle();
    int n;
    n = 0;
    while (d_busy !== 1'b0 && n < 300)
    begin
      @(negedge mclk_i);
      n++;
    end
    if (n == 300)
      give_up("operation end");
  endtask : wait_idle

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  logic [7:0] rcode [4] = '{8'hFF, 8'h90, 8'h98, 8'h70};
  logic [3:0] rmode [4] = '{FCD_RD_ARRAY, FCD_RD_ID, FCD_RD_QUERY, FCD_RD_STATUS};
  logic [7:0] lcode [3] = '{8'h01, 8'hD0, 8'h2F};
  logic [3:0] lkind [3] = '{FCD_OP_LOCK, FCD_OP_UNLOCK, FCD_OP_LDOWN};
  logic [7:0] pcode [2] = '{8'h40, 8'h10};

  initial
  begin
    repeat (8) @(negedge mclk_i);
    arst_n_i = 1'b1;
    @(negedge mclk_i);
    check({h_busy, h_done, rd_mode}, {2'b00, FCD_RD_ARRAY}, "idle after reset");
    // Mode codes at one address; reads would add the die base to the offset
    for (int i = 0; i < 4; i++)
    begin
      wr(24'h000100, {8'h00, rcode[i]});
      check(rd_mode, rmode[i], "read mode select");
    end
    $display("test read_modes done");
    wr(24'h020000, 16'h0020);
    wr(24'h020000, 16'h00FF);
    check(status[5:4], 2'b11, "bad confirm error bits");
    check(rd_mode, FCD_RD_STATUS, "bad confirm mode");
    wr(24'h000000, 16'h0050);
    check(status[5:4], 2'b00, "error bits cleared");
    $display("test bad_confirm done");
    wr(24'h030000, 16'h0020);
    wr(24'h030000, 16'h00D0);
    check({op_kind, op_addr, d_busy, status[7]}, {FCD_OP_ERASE, 24'h030000, 2'b10}, "erase running");
    check(rd_mode, FCD_RD_STATUS, "status mode on erase");
    wait_idle();
    check(status[7], 1'b1, "ready after erase");
    $display("test erase done");
    for (int i = 0; i < 2; i++)
    begin
      wr(24'h004000, {8'h00, pcode[i]});
      wr(24'h004000, 16'hA55A);
      check({op_kind, op_addr, op_data}, {FCD_OP_PROGRAM, 24'h004000, 16'hA55A}, "word program");
      wr(24'h000000, 16'h00FF);
      check(rd_mode, FCD_RD_STATUS, "command ignored while programming");
      wr(24'h000000, 16'h00B0);
      check({susp, status[6]}, 2'b11, "suspended");
      wr(24'h000000, 16'h00D0);
      check(susp, 1'b0, "resumed");
      wait_idle();
    end
    $display("test word_program done");
    for (int i = 0; i < 3; i++)
    begin
      wr(24'h050000, 16'h0060);
      wr(24'h050000, {8'h00, lcode[i]});
      check({op_kind, op_addr}, {lkind[i], 24'h050000}, "lock control");
    end
    wr(24'h005A3C, 16'h0060);
    wr(24'h005A3C, 16'h0003);
    check(cfg, 16'h5A3C, "config value from address");
    for (int i = 0; i < 2; i++)
    begin
      wr(24'h000080 + 24'(i), 16'h00C0);
      wr(24'h000080 + 24'(i), 16'h1234);
      check({op_kind, op_addr, op_data}, {FCD_OP_PROT, 24'h000080 + 24'(i), 16'h1234}, "register program");
      wait_idle();
    end
    $display("test lock_config_prot done");
    nbuf = 0;
    wr(24'h060000, 16'h00E8);
    wr(24'h060000, 16'h0003);
    for (int i = 0; i < 4; i++)
      wr(24'h060000 + 24'(i), 16'h0100 + 16'(i));
    check(nbuf, 4, "buffered words");
    check({buf_idx, op_addr, op_data}, {5'h03, 24'h060003, 16'h0103}, "last buffered word");
    wr(24'h060000, 16'h00D0);
    check({op_kind, d_busy}, {FCD_OP_BUF, 1'b1}, "buffer program running");
    wait_idle();
    nbuf = 0;
    wr(24'h070000, 16'h0080);
    wr(24'h070000, 16'h00D0);
    wr(24'h070000, 16'h00FF);
    check(nbuf, 1, "factory mode takes data");
    check(rd_mode, FCD_RD_STATUS, "factory mode ignores command");
    efp_exit_i = 1'b1;
    @(negedge mclk_i);
    efp_exit_i = 1'b0;
    wait_idle();
    $display("test buffer_factory done");
    wr(24'h080000, 16'h0020);
    wr(24'h080000, 16'h00D0);
    check(d_busy, 1'b1, "erase before abort");
    hw_reset_i = 1'b1;
    repeat (4) @(negedge mclk_i);
    check({aborted, d_busy, rd_mode, status}, {2'b10, FCD_RD_ARRAY, FCD_STATUS_RESET}, "pin abort");
    hw_reset_i = 1'b0;
    repeat (3) @(negedge mclk_i);
    $display("test pin_abort done");
    complete_run();
  end

  // Watchdog for the whole run
  initial
  begin
    #2000000;
    give_up("run limit");
  end
endmodule : testbench
